// ### rtl/mtc_pkg.sv
package mtc_pkg;

  // ==================================================================
  // Register indices (byte address is four times the index)
  // ==================================================================
  localparam logic [5:0] IDX_CAPTURE_ONE = 6'h10;   // Capture value one
  localparam logic [5:0] IDX_CAPTURE_TWO = 6'h12;   // Capture value two
  localparam logic [5:0] IDX_CAPTURE_THREE = 6'h14; // Capture value three
  localparam logic [5:0] IDX_COMPARE_ONE = 6'h16;   // Compare value one
  localparam logic [5:0] IDX_COMPARE_TWO = 6'h18;   // Compare value two
  localparam logic [5:0] IDX_COMPARE_THREE = 6'h1A; // Compare value three
  localparam logic [5:0] IDX_COMPARE_FOUR = 6'h1C;  // Compare value four
  localparam logic [5:0] IDX_SHARED = 6'h1E;        // Shared capture/compare
  localparam logic [5:0] IDX_EDGE_CTL = 6'h20;      // Capture edge control
  localparam logic [5:0] IDX_OUT_CTL = 6'h21;       // Compare mode/level
  localparam logic [5:0] IDX_TIMER_CTL = 6'h22;     // Prescaler, shared sel
  localparam logic [5:0] IDX_FLAGS = 6'h23;         // Event flags, W1C
  localparam logic [5:0] IDX_COUNT = 6'h24;         // Free-running counter

  // ==================================================================
  // Field positions
  // ==================================================================
  localparam int TCTL_PRESCALER_LSB = 0;   // Prescaler select [1:0]
  localparam int TCTL_SHARED_SEL_BIT = 2;  // 0 compare five, 1 capture four
  localparam int TCTL_LOCKED_BIT = 3;      // Read-only prescaler lock
  localparam int FLAG_OVERFLOW_BIT = 8;    // Counter wrap flag

  // ==================================================================
  // Reset values and counts
  // ==================================================================
  localparam logic [15:0] COMPARE_RESET = 16'hFFFF;
  localparam logic [7:0] EDGE_CTL_RESET = 8'h00;
  localparam logic [9:0] OUT_CTL_RESET = 10'h000;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [6:0] PRESCALER_WINDOW = 7'd64; // Write window, cycles

  // Divider terminal values for prescale 1, 4, 8, 16
  localparam logic [3:0] DIV_TERM_1 = 4'h0;
  localparam logic [3:0] DIV_TERM_4 = 4'h3;
  localparam logic [3:0] DIV_TERM_8 = 4'h7;
  localparam logic [3:0] DIV_TERM_16 = 4'hF;

  // Compare output actions {mode, level}
  typedef enum logic [1:0] {
    MTC_OC_DETACH = 2'b00,
    MTC_OC_TOGGLE = 2'b01,
    MTC_OC_CLEAR = 2'b10,
    MTC_OC_SET = 2'b11
  } mtc_oc_action_t;

endpackage

// ### rtl/mtc_edge_if.sv
`timescale 1ns/1ps
// Edge select down to a detector, qualified hit pulse back up
interface mtc_edge_if;
  logic [1:0] edge_sel; // {edge_select_high, edge_select_low}
  logic hit;            // One-cycle pulse on a qualifying edge
  modport detector (input edge_sel, output hit);
  modport owner (output edge_sel, input hit);
endinterface

// ### rtl/mtc_edge_detect.sv
`timescale 1ns/1ps
module mtc_edge_detect
  import mtc_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic pin,
  mtc_edge_if.detector det
);

  // ==================================================================
  // Three-stage synchroniser
  // ==================================================================
  logic [2:0] sync_reg; // [0] only feeds [1]
  logic [2:0] sync_next;
  logic level_reg; // Last level on which stages two and three agreed
  logic level_next;
  logic agree; // Stages two and three hold the same level
  logic rise;
  logic fall;

  // Shift chain; the agreed level only moves when two stages match
  always_comb begin
    sync_next = {sync_reg[1:0], pin};
    agree = (sync_reg[1] == sync_reg[2]);
    level_next = agree ? sync_reg[2] : level_reg;
  end

  // Agreed level resets to the pin's idle low, so no false edge
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sync_reg <= 3'h0;
      level_reg <= 1'b0;
    end else begin
      sync_reg <= sync_next;
      level_reg <= level_next;
    end
  end

  // ==================================================================
  // Edge qualification
  // ==================================================================
  // A change counts once stages two and three agree on a new level
  always_comb begin
    rise = agree & sync_reg[2] & ~level_reg;
    fall = agree & ~sync_reg[2] & level_reg;
    det.hit = (det.edge_sel[0] & rise) | (det.edge_sel[1] & fall);
  end

endmodule

// ### rtl/mtc_timer.sv
// Design decision made here: register access over AHB-Lite.
`timescale 1ns/1ps
module mtc_timer
  import mtc_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [ADDR_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [3:0] capture_input,
  output logic [4:0] compare_output_line,
  output logic [4:0] compare_output_enable
);

  // ==================================================================
  // Bus address phase capture
  // ==================================================================
  logic wr_pend_reg; // Write data phase pending
  logic wr_pend_next;
  logic [5:0] wr_idx_reg; // Index of pending write
  logic [5:0] wr_idx_next;
  logic [31:0] rdata_reg; // Read data, loaded in address phase
  logic [31:0] rdata_next;
  logic addr_ok; // Valid NONSEQ or SEQ address phase
  logic [5:0] a_idx;
  logic wr_en; // Write data phase this cycle

  // ==================================================================
  // Timer state
  // ==================================================================
  logic [15:0] count_reg; // Free-running counter
  logic [15:0] count_next;
  logic [3:0] div_reg; // Prescale divider
  logic [3:0] div_next;
  logic [1:0] pre_reg; // Prescaler select
  logic [1:0] pre_next;
  logic locked_reg; // Prescaler can no longer change
  logic locked_next;
  logic [6:0] window_reg; // Cycles since reset, saturating
  logic [6:0] window_next;
  logic shared_sel_reg; // Shared channel role
  logic shared_sel_next;
  logic [7:0] edge_reg; // Capture edge control
  logic [7:0] edge_next;
  logic [9:0] outctl_reg; // {mode,level} per compare channel
  logic [9:0] outctl_next;
  logic [15:0] cmp_reg [4]; // Compare values one to four
  logic [15:0] cmp_next [4];
  logic [15:0] shared_reg; // Shared capture/compare value
  logic [15:0] shared_next;
  logic [15:0] cap_reg [3]; // Capture values, no reset
  logic [8:0] flags_reg; // {overflow, oc1..oc4, shared, ic1..ic3}
  logic [8:0] flags_next;
  logic [4:0] oc_reg; // Compare output lines
  logic [4:0] oc_next;
  logic tick; // Counter advance enable
  logic [3:0] hits; // Capture hits, channels one to four
  logic [4:0] match; // Compare matches, channels one to five
  logic [15:0] count_inc;

  mtc_edge_if edge_ch [4] ();

  // Divider terminal value for a prescale code
  function automatic logic [3:0] div_term(input logic [1:0] code);
    unique case (code)
      2'b00: div_term = DIV_TERM_1;
      2'b01: div_term = DIV_TERM_4;
      2'b10: div_term = DIV_TERM_8;
      2'b11: div_term = DIV_TERM_16;
    endcase
  endfunction

  // Edge select pair for channel n (0..2 = one..three, 3 = four)
  function automatic logic [1:0] edge_pair(input logic [7:0] ctl,
                                           input int n);
    unique case (n)
      0: edge_pair = ctl[5:4];
      1: edge_pair = ctl[3:2];
      2: edge_pair = ctl[1:0];
      default: edge_pair = ctl[7:6];
    endcase
  endfunction

  // ==================================================================
  // Capture edge detectors
  // ==================================================================
  generate
    for (genvar g = 0; g < 4; g++) begin : gen_cap
      assign edge_ch[g].edge_sel = edge_pair(edge_reg, g);
      mtc_edge_detect u_det (
        .clock(clock),
        .rst(rst),
        .pin(capture_input[g]),
        .det(edge_ch[g])
      );
      // Channel four only counts while the shared channel captures
      if (g == 3) begin : gen_shared
        assign hits[g] = edge_ch[g].hit & shared_sel_reg;
      end else begin : gen_ded
        assign hits[g] = edge_ch[g].hit;
      end
    end
  endgenerate

  // ==================================================================
  // Bus decode; zero wait states, always OKAY
  // ==================================================================
  always_comb begin
    addr_ok = hsel & hready & htrans[1];
    a_idx = haddr[7:2];
    wr_en = wr_pend_reg;
    wr_pend_next = addr_ok & hwrite;
    wr_idx_next = addr_ok ? a_idx : wr_idx_reg;
    rdata_next = rdata_reg;
    if (addr_ok & ~hwrite) begin
      // Unmapped indices read as zero
      unique case (a_idx)
        IDX_CAPTURE_ONE: rdata_next = {16'h0000, cap_reg[0]};
        IDX_CAPTURE_TWO: rdata_next = {16'h0000, cap_reg[1]};
        IDX_CAPTURE_THREE: rdata_next = {16'h0000, cap_reg[2]};
        IDX_COMPARE_ONE: rdata_next = {16'h0000, cmp_reg[0]};
        IDX_COMPARE_TWO: rdata_next = {16'h0000, cmp_reg[1]};
        IDX_COMPARE_THREE: rdata_next = {16'h0000, cmp_reg[2]};
        IDX_COMPARE_FOUR: rdata_next = {16'h0000, cmp_reg[3]};
        IDX_SHARED: rdata_next = {16'h0000, shared_reg};
        IDX_EDGE_CTL: rdata_next = {24'h000000, edge_reg};
        IDX_OUT_CTL: rdata_next = {22'h000000, outctl_reg};
        IDX_TIMER_CTL: rdata_next = {28'h0000000, locked_reg,
                                     shared_sel_reg, pre_reg};
        IDX_FLAGS: rdata_next = {23'h000000, flags_reg};
        IDX_COUNT: rdata_next = {16'h0000, count_reg};
        default: rdata_next = 32'h00000000;
      endcase
    end
    hrdata = rdata_reg;
    hreadyout = 1'b1;
    hresp = 1'b0;
  end

  // ==================================================================
  // Prescaler and counter
  // ==================================================================
  always_comb begin
    tick = (div_reg == div_term(pre_reg));
    div_next = tick ? 4'h0 : 4'(div_reg + 4'h1);
    count_inc = 16'(count_reg + 16'h0001);
    count_next = tick ? count_inc : count_reg;
    window_next = (window_reg == PRESCALER_WINDOW) ? window_reg :
                  7'(window_reg + 7'd1);
    pre_next = pre_reg;
    locked_next = locked_reg | (window_reg == PRESCALER_WINDOW);
    shared_sel_next = shared_sel_reg;
    if (wr_en && wr_idx_reg == IDX_TIMER_CTL) begin
      shared_sel_next = hwdata[TCTL_SHARED_SEL_BIT];
      // One write only, and only inside the window after reset
      if (!locked_reg) begin
        pre_next = hwdata[TCTL_PRESCALER_LSB +: 2];
        locked_next = 1'b1;
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      div_reg <= 4'h0;
      count_reg <= COUNT_RESET;
      window_reg <= 7'd0;
      pre_reg <= 2'b00;
      locked_reg <= 1'b0;
      shared_sel_reg <= 1'b0;
    end else begin
      div_reg <= div_next;
      count_reg <= count_next;
      window_reg <= window_next;
      pre_reg <= pre_next;
      locked_reg <= locked_next;
      shared_sel_reg <= shared_sel_next;
    end
  end

  // ==================================================================
  // Compare registers, shared register, control
  // ==================================================================
  always_comb begin
    cmp_next = cmp_reg;
    edge_next = edge_reg;
    outctl_next = outctl_reg;
    shared_next = shared_reg;
    if (wr_en) begin
      unique case (wr_idx_reg)
        IDX_COMPARE_ONE: cmp_next[0] = hwdata[15:0];
        IDX_COMPARE_TWO: cmp_next[1] = hwdata[15:0];
        IDX_COMPARE_THREE: cmp_next[2] = hwdata[15:0];
        IDX_COMPARE_FOUR: cmp_next[3] = hwdata[15:0];
        IDX_EDGE_CTL: edge_next = hwdata[7:0];
        IDX_OUT_CTL: outctl_next = hwdata[9:0];
        IDX_SHARED: begin
          // Writes dropped while the shared channel captures
          if (!shared_sel_reg) begin
            shared_next = hwdata[15:0];
          end
        end
        default: begin
        end
      endcase
    end
    // Capture on channel four overrides a same-cycle write
    if (hits[3]) begin
      shared_next = count_reg;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < 4; i++) begin
        cmp_reg[i] <= COMPARE_RESET;
      end
      shared_reg <= COMPARE_RESET;
      edge_reg <= EDGE_CTL_RESET;
      outctl_reg <= OUT_CTL_RESET;
    end else begin
      cmp_reg <= cmp_next;
      shared_reg <= shared_next;
      edge_reg <= edge_next;
      outctl_reg <= outctl_next;
    end
  end

  // Capture values keep their contents through reset
  always_ff @(posedge clock) begin
    for (int i = 0; i < 3; i++) begin
      if (hits[i]) begin
        cap_reg[i] <= count_reg;
      end
    end
  end

  // ==================================================================
  // Matches, output lines, flags
  // ==================================================================
  // Match on the tick that brings the counter to the compare value
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      match[i] = tick & (count_inc == cmp_reg[i]);
    end
    match[4] = tick & ~shared_sel_reg & (count_inc == shared_reg);
    oc_next = oc_reg;
    for (int i = 0; i < 5; i++) begin
      compare_output_enable[i] =
        (outctl_reg[2*i +: 2] != MTC_OC_DETACH);
      if (match[i]) begin
        unique case (mtc_oc_action_t'(outctl_reg[2*i +: 2]))
          MTC_OC_DETACH: oc_next[i] = oc_reg[i];
          MTC_OC_TOGGLE: oc_next[i] = ~oc_reg[i];
          MTC_OC_CLEAR: oc_next[i] = 1'b0;
          MTC_OC_SET: oc_next[i] = 1'b1;
        endcase
      end
    end
    // Shared line released while the channel captures
    compare_output_enable[4] = compare_output_enable[4] & ~shared_sel_reg;
    compare_output_line = oc_reg;
    // Hardware set wins over a same-cycle write-one clear
    flags_next = flags_reg;
    if (wr_en && wr_idx_reg == IDX_FLAGS) begin
      flags_next = flags_reg & ~hwdata[8:0];
    end
    flags_next = flags_next | {tick & (count_reg == 16'hFFFF),
                               match[0], match[1], match[2], match[3],
                               match[4] | hits[3],
                               hits[0], hits[1], hits[2]};
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wr_pend_reg <= 1'b0;
      wr_idx_reg <= 6'h00;
      rdata_reg <= 32'h00000000;
      oc_reg <= 5'h00;
      flags_reg <= 9'h000;
    end else begin
      wr_pend_reg <= wr_pend_next;
      wr_idx_reg <= wr_idx_next;
      rdata_reg <= rdata_next;
      oc_reg <= oc_next;
      flags_reg <= flags_next;
    end
  end

endmodule

// ### bench/mtc_timer_props.sv
`timescale 1ns/1ps
// ==========================================
// Port-level checker for the timer
module mtc_timer_props
  import mtc_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [ADDR_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [4:0] compare_output_line,
  input wire logic [4:0] compare_output_enable
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  logic [5:0] idx_q; // Index in data phase
  logic wr_q; // Write in data phase
  logic rd_q; // Read in data phase
  logic [9:0] out_sh; // Output control shadow
  logic [7:0] edge_sh; // Edge control shadow
  logic sel_sh; // Shared select shadow
  logic [4:0] en_exp; // Expected pin enables
  // Shadows land at the data-phase edge, as the slave's writes do
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      idx_q <= 6'h00;
      out_sh <= OUT_CTL_RESET;
      edge_sh <= EDGE_CTL_RESET;
      sel_sh <= 1'b0;
    end else begin
      wr_q <= hsel && hready && htrans[1] && hwrite;
      rd_q <= hsel && hready && htrans[1] && !hwrite;
      idx_q <= haddr[7:2];
      if (wr_q && idx_q == IDX_OUT_CTL) out_sh <= hwdata[9:0];
      if (wr_q && idx_q == IDX_EDGE_CTL) edge_sh <= hwdata[7:0];
      if (wr_q && idx_q == IDX_TIMER_CTL) sel_sh <= hwdata[2];
    end
  end
  // Channel five is masked while the shared channel captures
  always_comb begin
    for (int i = 0; i < 5; i++) en_exp[i] = out_sh[2*i+:2] != 2'b00;
    en_exp[4] = en_exp[4] && !sel_sh;
  end
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus not ready or not okay");
  a_reset_idle: assert property (disable iff (1'b0) rst |->
    compare_output_line == 5'h00 && compare_output_enable == 5'h00)
    else $error("pins active in reset");
  a_enable_map: assert property (compare_output_enable == en_exp)
    else $error("enable not from mode and select");
  a_line_detached: assert property (
    ((compare_output_line ^ $past(compare_output_line))
     & ~$past(compare_output_enable)) == 5'h00)
    else $error("detached line moved");
  a_upper_zero: assert property (rd_q |-> hrdata[31:16] == 16'h0000)
    else $error("upper read bits set");
  a_out_readback: assert property (rd_q && idx_q == IDX_OUT_CTL |->
    hrdata[9:0] == out_sh) else $error("output control readback");
  a_edge_readback: assert property (rd_q && idx_q == IDX_EDGE_CTL |->
    hrdata[7:0] == edge_sh) else $error("edge control readback");
  a_sel_readback: assert property (rd_q && idx_q == IDX_TIMER_CTL |->
    hrdata[2] == sel_sh) else $error("shared select readback");
  c_count_read: cover property (rd_q && idx_q == IDX_COUNT);
  c_line_rise: cover property ($rose(compare_output_line[0]));
  c_five_masked: cover property (sel_sh && out_sh[9:8] != 2'b00);
endmodule

// ### bench/mtc_pins_model.sv
`timescale 1ns/1ps
// ==========================================
// Off-chip pins: capture sources and pulled-up compare pads
module mtc_pins_model (
  input wire logic clock,
  input wire logic rst,
  input wire logic [3:0] level_req,
  input wire logic [4:0] compare_output_line,
  input wire logic [4:0] compare_output_enable,
  output logic [3:0] capture_input,
  output logic [4:0] pad_level
);
  logic phase; // Updates every second edge
  // Levels hold two clocks at least, the shortest pulse allowed
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      phase <= 1'b0;
      capture_input <= 4'h0;
    end else begin
      phase <= !phase;
      if (phase) capture_input <= level_req;
    end
  end
  // Released pads go to the pull-up level
  assign pad_level = (compare_output_line & compare_output_enable)
                     | ~compare_output_enable;
endmodule

// ### bench/mtc_timer_bench.sv
`timescale 1ns/1ps
// ==========================================
// Register-level bench for the timer
module mtc_timer_bench;
  import mtc_pkg::*;
  logic clock = 1'b0;
  logic rst = 1'b0; // Raised at time zero so the async reset fires
  logic hsel = 1'b0;
  logic [7:0] haddr = 8'h00;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic [3:0] pins = 4'h0; // Requested capture levels
  logic [3:0] capture_input;
  logic [4:0] line;
  logic [4:0] en;
  logic [4:0] pad;
  logic [31:0] q, c, v, s;
  int failures = 0;
  int compares = 0;
  logic [1:0] acts [3] = '{2'b11, 2'b10, 2'b01}; // Set, clear, toggle
  always #50 clock = !clock;
  mtc_timer u_dut (.clock(clock), .rst(rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .capture_input(capture_input),
    .compare_output_line(line), .compare_output_enable(en));
  mtc_pins_model u_pins (.clock(clock), .rst(rst), .level_req(pins),
    .compare_output_line(line), .compare_output_enable(en),
    .capture_input(capture_input), .pad_level(pad));
  task automatic final_report();
    if (failures == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Bounded wait for hready at a rising edge
  task automatic wait_ready();
    int n;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (n >= 50) begin
      failures++;
      final_report();
    end
  endtask
  // One single AHB-Lite word transfer
  task automatic bus(input logic [7:0] a, input logic w,
                     input logic [31:0] d, output logic [31:0] r);
    @(posedge clock);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'b10;
    wait_ready();
    htrans <= 2'b00;
    hwdata <= d;
    wait_ready();
    r = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(a, 1'b1, d, r);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    bus(a, 1'b0, 32'h0, r);
  endtask
  task automatic check(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
    compares++;
    if (g !== e) begin
      failures++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Counter steps over 40 cycles, address edges 40 apart
  task automatic steps(output logic [31:0] d);
    logic [31:0] a, b;
    rd(8'h90, a);
    repeat (37) @(posedge clock);
    rd(8'h90, b);
    d = {16'h0, b[15:0] - a[15:0]};
  endtask
  initial begin
    rst <= 1'b1;
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    wr(8'h88, 32'h1);
    steps(q);
    check("ticks by four", 32'hA, q);
    wr(8'h88, 32'h3);
    steps(q);
    check("second prescale", 32'hA, q);
    for (int a = 8'h58; a <= 8'h78; a += 8) begin
      rd(a[7:0], q);
      check("compare reset", 32'hFFFF, q);
    end
    rd(8'h80, q);
    check("edge reset", 32'h0, q);
    rd(8'hFC, q);
    check("unmapped", 32'h0, q);
    foreach (acts[k]) begin
      wr(8'h84, {30'h0, acts[k]});
      rd(8'h90, c);
      wr(8'h58, {16'h0, c[15:0] + 16'h10});
      repeat (120) @(posedge clock);
      check("compare pad", {31'h0, k != 1}, {31'h0, pad[0]});
      rd(8'h8C, q);
      check("compare flag", 32'h1, {31'h0, q[7]});
      wr(8'h8C, 32'h80);
    end
    rd(8'h8C, q);
    check("flag cleared", 32'h0, {31'h0, q[7]});
    wr(8'h84, 32'h0);
    @(posedge clock);
    check("detached pad", 32'h1, {31'h0, pad[0]});
    wr(8'h88, 32'h5);
    wr(8'h80, 32'h7B);
    wr(8'h8C, 32'h1FF);
    rd(8'h90, c);
    pins <= 4'hF;
    repeat (10) @(posedge clock);
    rd(8'h8C, q);
    check("rise flags", 32'hD, {28'h0, q[3:0]});
    rd(8'h40, v);
    check("capture time", 32'h1, {31'h0, v[15:0] - c[15:0] <= 16'h3});
    rd(8'h78, s);
    check("shared time", 32'h1, {31'h0, s[15:0] - c[15:0] <= 16'h3});
    wr(8'h78, 32'h1234);
    rd(8'h78, q);
    check("shared kept", s, q);
    wr(8'h8C, 32'h1FF);
    pins <= 4'h0;
    repeat (10) @(posedge clock);
    rd(8'h8C, q);
    check("fall flags", 32'h7, {28'h0, q[3:0]});
    wr(8'h88, 32'h1);
    wr(8'h78, 32'h1234);
    rd(8'h78, q);
    check("shared compare", 32'h1234, q);
    rd(8'h40, v);
    @(posedge clock);
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    rd(8'h40, q);
    check("capture kept", v, q);
    rd(8'h58, q);
    check("compare again", 32'hFFFF, q);
    // Window closed: prescaler stays at one count per cycle
    repeat (70) @(posedge clock);
    wr(8'h88, 32'h3);
    steps(q);
    check("window locked", 32'h28, q);
    // One full counter period: wrap and every compare at all ones
    wr(8'h8C, 32'h1FF);
    repeat (65536) @(posedge clock);
    rd(8'h8C, q);
    check("wrap flags", 32'h1F8, {23'h0, q[8:0]});
    final_report();
  end
endmodule
bind mtc_timer mtc_timer_props #(.ADDR_W(ADDR_W)) u_props (.clock(clock),
  .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp),
  .compare_output_line(compare_output_line),
  .compare_output_enable(compare_output_enable));
